// file: rtl/fast_counter.sv
// bidirectional 16-bit preset counter with apb register file
// assumes apb3 master on clock_i, count pins synchronous to clock_i
// Function
// - pulse/direction: edge counts, direction picks sign
// - up/down: input 0 up, input 1 down
// - low preset below high, else code 37h
// - hardware low preset resets to -32768
// - signed 16-bit range, zero command clears
// - first rung copies image accumulator and high
// - later only commands change accumulator or presets
// - high hit: step, load above, preset below
// - high hit sets flag, one-hot cause, request
// - high hit keeps accumulator and high preset
// - low hit: step, load below, preset above
// - low hit sets flag, one-hot cause, request
// - wrap up sets wrap-high flag and cause
// - wrap down sets wrap-low flag and cause
// - rung false ignores count edges, reset edge still clears
// - hold freezes, reset edge forces zero
// - simultaneous up and down nets zero
`timescale 1ns/1ps
module fast_counter (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   input wire logic [3:0] count_in_i,
   output logic irq_o,
   output logic irq_pulse_o
);
   localparam int CW = fast_counter_pkg::CNT_W;
   localparam int SW = fast_counter_pkg::STAT_W;
   localparam int EW = fast_counter_pkg::EV_W;

   function automatic logic [EW-1:0] pick_cause(input logic [EW-1:0] ev);
      logic [EW-1:0] r;
      r = '0;
      if (ev[fast_counter_pkg::LOW_BIT]) begin
         r[fast_counter_pkg::LOW_BIT] = 1'b1;
      end else if (ev[fast_counter_pkg::WRAP_LOW_BIT]) begin
         r[fast_counter_pkg::WRAP_LOW_BIT] = 1'b1;
      end else if (ev[fast_counter_pkg::HIGH_BIT]) begin
         r[fast_counter_pkg::HIGH_BIT] = 1'b1;
      end else if (ev[fast_counter_pkg::WRAP_HIGH_BIT]) begin
         r[fast_counter_pkg::WRAP_HIGH_BIT] = 1'b1;
      end
      return r;
   endfunction

   function automatic logic [31:0] widen(input logic [CW-1:0] v);
      return {{(32-CW){1'b0}}, v};
   endfunction

   fast_counter_pkg::ctrl_s ctrl_reg;
   fast_counter_pkg::run_state_e state_reg, state_next;
   logic signed [CW-1:0] img_acc_reg, img_high_reg, img_low_reg;
   logic signed [CW-1:0] acc_reg, acc_next, high_reg, high_next;
   logic signed [CW-1:0] low_reg, low_next;
   logic [SW-1:0] status_reg, status_next, mask_reg;
   logic [EW-1:0] cause_reg, cause_next;
   logic [7:0] err_reg;
   logic [31:0] prdata_reg;
   logic irq_pulse_reg;

   // apb decode
   wire setup_rd = psel_i & ~penable_i & ~pwrite_i & ce_i;
   wire access = psel_i & penable_i & ce_i;
   wire wr_en = access & pwrite_i;
   wire a_ctrl = paddr_i == fast_counter_pkg::CTRL_OFS;
   wire a_cmd = paddr_i == fast_counter_pkg::CMD_OFS;
   wire a_iacc = paddr_i == fast_counter_pkg::IMG_ACC_OFS;
   wire a_ihigh = paddr_i == fast_counter_pkg::IMG_HIGH_OFS;
   wire a_ilow = paddr_i == fast_counter_pkg::IMG_LOW_OFS;
   wire a_hacc = paddr_i == fast_counter_pkg::HW_ACC_OFS;
   wire a_hhigh = paddr_i == fast_counter_pkg::HW_HIGH_OFS;
   wire a_hlow = paddr_i == fast_counter_pkg::HW_LOW_OFS;
   wire a_stat = paddr_i == fast_counter_pkg::STATUS_OFS;
   wire a_mask = paddr_i == fast_counter_pkg::MASK_OFS;
   wire a_cause = paddr_i == fast_counter_pkg::CAUSE_OFS;
   wire a_err = paddr_i == fast_counter_pkg::ERR_OFS;
   wire a_hit = a_ctrl | a_cmd | a_iacc | a_ihigh | a_ilow | a_hacc |
      a_hhigh | a_hlow | a_stat | a_mask | a_cause | a_err;
   wire [31:0] rd_word =
      a_ctrl ? {28'h0000000, ctrl_reg} :
      a_iacc ? widen(img_acc_reg) :
      a_ihigh ? widen(img_high_reg) :
      a_ilow ? widen(img_low_reg) :
      a_hacc ? widen(acc_reg) :
      a_hhigh ? widen(high_reg) :
      a_hlow ? widen(low_reg) :
      a_stat ? {27'h0000000, status_reg} :
      a_mask ? {27'h0000000, mask_reg} :
      a_cause ? {28'h0000000, cause_reg} :
      a_err ? {24'h000000, err_reg} : 32'h00000000;
   wire [SW-1:0] stat_clr = (wr_en & a_stat) ? pwdata_i[SW-1:0] : '0;

   // commands pulse on an accepted write
   wire zero_cmd = wr_en & a_cmd & pwdata_i[fast_counter_pkg::CMD_ZERO_BIT];
   wire load_cmd = wr_en & a_cmd & pwdata_i[fast_counter_pkg::CMD_LOAD_BIT];
   wire limit_cmd = wr_en & a_cmd &
      pwdata_i[fast_counter_pkg::CMD_LIMIT_BIT];

   // input pins
   logic [3:0] rise;
   input_edges #(
      .W(fast_counter_pkg::NUM_IN)
   ) u_edges (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .level_i(count_in_i),
      .rise_o(rise)
   );

   wire running = state_reg == fast_counter_pkg::ST_RUN;
   wire first_copy = (state_reg == fast_counter_pkg::ST_WAIT) &
      ctrl_reg.rung & ce_i;
   wire ext_reset = ctrl_reg.reset_hold &
      rise[fast_counter_pkg::PIN_RESET];
   wire hold_pin = ctrl_reg.reset_hold &
      count_in_i[fast_counter_pkg::PIN_HOLD];
   wire acc_load = ext_reset | zero_cmd | load_cmd | first_copy;
   wire signed [CW-1:0] load_val = (ext_reset | zero_cmd) ?
      fast_counter_pkg::CNT_ZERO : img_acc_reg;
   wire count_ok = running & ctrl_reg.rung & ~hold_pin &
      ~acc_load;
   wire dir_pin = count_in_i[fast_counter_pkg::PIN_DIR];
   wire up_ev = count_ok & (ctrl_reg.up_down ?
      rise[fast_counter_pkg::PIN_COUNT] :
      rise[fast_counter_pkg::PIN_COUNT] & ~dir_pin);
   wire dn_ev = count_ok & (ctrl_reg.up_down ?
      rise[fast_counter_pkg::PIN_DIR] :
      rise[fast_counter_pkg::PIN_COUNT] & dir_pin);

   // increment first, then decrement
   wire signed [CW-1:0] mid_val = up_ev ? acc_reg + 16'sh0001 : acc_reg;
   wire signed [CW-1:0] fin_val = dn_ev ? mid_val - 16'sh0001 : mid_val;
   wire wrap_up = up_ev & (acc_reg == fast_counter_pkg::CNT_MAX);
   wire wrap_dn = dn_ev & (mid_val == fast_counter_pkg::CNT_MIN);

   // preset loads, checked against each other
   wire lim_ok = limit_cmd & (img_low_reg < img_high_reg);
   wire copy_ok = first_copy & (low_reg < img_high_reg);
   wire err_ev = (limit_cmd & ~lim_ok) | (first_copy & ~copy_ok);
   wire high_load = lim_ok | copy_ok;
   assign high_next = high_load ? img_high_reg : high_reg;
   assign low_next = lim_ok ? img_low_reg : low_reg;
   assign acc_next = acc_load ? load_val : fin_val;

   wire hit_high = (up_ev & (mid_val == high_next)) |
      (acc_load & (acc_next >= high_next)) |
      (high_load & (high_next <= acc_next));
   wire hit_low = (dn_ev & (fin_val == low_next)) |
      (acc_load & (acc_next <= low_next)) |
      (lim_ok & (low_next >= acc_next));
   wire [EW-1:0] ev;
   assign ev[fast_counter_pkg::HIGH_BIT] = hit_high;
   assign ev[fast_counter_pkg::LOW_BIT] = hit_low;
   assign ev[fast_counter_pkg::WRAP_HIGH_BIT] = wrap_up;
   assign ev[fast_counter_pkg::WRAP_LOW_BIT] = wrap_dn;
   wire any_ev = |ev;

   // set beats a same-cycle write-one clear
   assign status_next = (status_reg & ~stat_clr) | {err_ev, ev};
   assign cause_next = any_ev ? pick_cause(ev) : cause_reg;
   assign state_next = first_copy ? fast_counter_pkg::ST_RUN : state_reg;

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         state_reg <= fast_counter_pkg::ST_WAIT;
         acc_reg <= fast_counter_pkg::CNT_ZERO;
         high_reg <= fast_counter_pkg::HIGH_RESET;
         low_reg <= fast_counter_pkg::LOW_RESET;
      end else if (ce_i) begin
         state_reg <= state_next;
         acc_reg <= acc_next;
         high_reg <= high_next;
         low_reg <= low_next;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         status_reg <= '0;
         cause_reg <= '0;
         err_reg <= fast_counter_pkg::ERR_NONE;
         irq_pulse_reg <= 1'b0;
      end else if (ce_i) begin
         status_reg <= status_next;
         cause_reg <= cause_next;
         irq_pulse_reg <= any_ev & ctrl_reg.irq_en;
         if (err_ev) begin
            err_reg <= fast_counter_pkg::ERR_PRESET;
         end else if (stat_clr[fast_counter_pkg::ERR_BIT]) begin
            err_reg <= fast_counter_pkg::ERR_NONE;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         ctrl_reg <= '0;
         mask_reg <= '0;
         img_acc_reg <= fast_counter_pkg::CNT_ZERO;
         img_high_reg <= fast_counter_pkg::HIGH_RESET;
         img_low_reg <= fast_counter_pkg::LOW_RESET;
      end else if (wr_en) begin
         if (a_ctrl) ctrl_reg <= pwdata_i[3:0];
         if (a_mask) mask_reg <= pwdata_i[SW-1:0];
         if (a_iacc) img_acc_reg <= pwdata_i[CW-1:0];
         if (a_ihigh) img_high_reg <= pwdata_i[CW-1:0];
         if (a_ilow) img_low_reg <= pwdata_i[CW-1:0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         prdata_reg <= 32'h00000000;
      end else if (setup_rd) begin
         prdata_reg <= rd_word;
      end
   end

   assign pready_o = ce_i;
   assign pslverr_o = psel_i & penable_i & ~a_hit;
   assign prdata_o = prdata_reg;
   assign irq_o = |(status_reg & mask_reg);
   assign irq_pulse_o = irq_pulse_reg;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!reset_n_i);

   wire [1:0] both_rise = rise[1:0];

   // checker helper: low preset loaded since reset
   logic low_loaded_reg;

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         low_loaded_reg <= 1'b0;
      end else if (lim_ok) begin
         low_loaded_reg <= 1'b1;
      end
   end

   pd_count_up_a: assert property (
      ce_i && running && ctrl_reg.rung && !ctrl_reg.up_down && !acc_load &&
      !hold_pin && rise[0] && !dir_pin
      |=> acc_reg == $past(acc_reg) + 16'sh0001)
      else $error("pulse up count wrong");
   pd_count_dn_a: assert property (
      ce_i && running && ctrl_reg.rung && !ctrl_reg.up_down && !acc_load &&
      !hold_pin && rise[0] && dir_pin
      |=> acc_reg == $past(acc_reg) - 16'sh0001)
      else $error("pulse down count wrong");
   ud_down_a: assert property (
      ce_i && running && ctrl_reg.rung && ctrl_reg.up_down && !acc_load &&
      !hold_pin && both_rise == 2'b10
      |=> acc_reg == $past(acc_reg) - 16'sh0001)
      else $error("up/down decrement wrong");
   preset_err_a: assert property (
      ce_i && limit_cmd && img_low_reg >= img_high_reg
      |=> err_reg == 8'h37 && status_reg[4] && $stable(low_reg))
      else $error("bad presets not refused");
   low_default_a: assert property (
      !low_loaded_reg |-> low_reg == fast_counter_pkg::LOW_RESET)
      else $error("low preset default lost");
   zero_cmd_a: assert property (
      ce_i && zero_cmd |=> acc_reg == 16'sh0000)
      else $error("zero command failed");
   first_copy_a: assert property (
      first_copy && !zero_cmd && !ext_reset
      |=> acc_reg == $past(img_acc_reg) && running)
      else $error("first copy failed");
   limits_only_a: assert property (
      ce_i && !lim_ok && !first_copy
      |=> $stable(low_reg) && $stable(high_reg))
      else $error("presets changed without load");
   high_load_hit_a: assert property (
      ce_i && high_load && !acc_load && !up_ev && !dn_ev &&
      img_high_reg <= acc_reg
      |=> status_reg[fast_counter_pkg::HIGH_BIT])
      else $error("high preset load hit missed");
   high_hit_a: assert property (
      ce_i && hit_high && !hit_low && !wrap_dn
      |=> status_reg[0] && cause_reg == 4'b0001)
      else $error("high hit not flagged");
   high_keep_a: assert property (
      ce_i && hit_high && !acc_load && !dn_ev && !high_load
      |=> acc_reg == $past(mid_val) && $stable(high_reg))
      else $error("high hit changed counter");
   low_load_hit_a: assert property (
      ce_i && lim_ok && !acc_load && !up_ev && !dn_ev &&
      img_low_reg >= acc_reg
      |=> status_reg[fast_counter_pkg::LOW_BIT])
      else $error("low preset load hit missed");
   low_hit_a: assert property (
      ce_i && hit_low |=> status_reg[1] && cause_reg == 4'b0010)
      else $error("low hit not flagged");
   wrap_high_a: assert property (
      ce_i && wrap_up && !dn_ev
      |=> status_reg[2] && acc_reg == 16'sh8000)
      else $error("wrap high not flagged");
   wrap_low_a: assert property (
      ce_i && wrap_dn |=> status_reg[3] && acc_reg == 16'sh7fff)
      else $error("wrap low not flagged");
   rung_hold_a: assert property (
      ce_i && !ctrl_reg.rung && !acc_load |=> $stable(acc_reg))
      else $error("count moved with rung false");
   ext_reset_a: assert property (
      ce_i && ext_reset |=> acc_reg == 16'sh0000)
      else $error("reset pin did not clear");
   both_edges_a: assert property (
      ce_i && ctrl_reg.up_down && count_ok && both_rise == 2'b11
      |=> $stable(acc_reg))
      else $error("simultaneous edges changed count");
   irq_pulse_a: assert property (
      ce_i |=> irq_pulse_o == ($past(any_ev) && $past(ctrl_reg.irq_en)))
      else $error("interrupt pulse mismatch");

   hit_high_c: cover property (ce_i && hit_high ##1 irq_o);
   wrap_low_c: cover property (ce_i && wrap_dn);
   ext_reset_c: cover property (running ##1 ce_i && ext_reset);
   both_edges_c: cover property (count_ok && both_rise == 2'b11);
endmodule // fast_counter

// file: rtl/fast_counter_pkg.sv
// constants, register map and carrier types of the fast counter
// assumes a 32-bit apb master and a 50 mhz system clock
package fast_counter_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W = 16;
   localparam int NUM_IN = 4;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CMD_OFS = 8'h04;
   localparam logic [7:0] IMG_ACC_OFS = 8'h08;
   localparam logic [7:0] IMG_HIGH_OFS = 8'h0c;
   localparam logic [7:0] IMG_LOW_OFS = 8'h10;
   localparam logic [7:0] HW_ACC_OFS = 8'h14;
   localparam logic [7:0] HW_HIGH_OFS = 8'h18;
   localparam logic [7:0] HW_LOW_OFS = 8'h1c;
   localparam logic [7:0] STATUS_OFS = 8'h20;
   localparam logic [7:0] MASK_OFS = 8'h24;
   localparam logic [7:0] CAUSE_OFS = 8'h28;
   localparam logic [7:0] ERR_OFS = 8'h2c;
   // command bits
   localparam int CMD_ZERO_BIT = 0;
   localparam int CMD_LOAD_BIT = 1;
   localparam int CMD_LIMIT_BIT = 2;
   // status, mask and cause bit positions
   localparam int HIGH_BIT = 0;
   localparam int LOW_BIT = 1;
   localparam int WRAP_HIGH_BIT = 2;
   localparam int WRAP_LOW_BIT = 3;
   localparam int ERR_BIT = 4;
   localparam int EV_W = 4;
   localparam int STAT_W = 5;
   // input pin positions
   localparam int PIN_COUNT = 0;
   localparam int PIN_DIR = 1;
   localparam int PIN_RESET = 2;
   localparam int PIN_HOLD = 3;
   // values
   localparam logic signed [15:0] CNT_MAX = 16'sh7fff;
   localparam logic signed [15:0] CNT_MIN = 16'sh8000;
   localparam logic signed [15:0] CNT_ZERO = 16'sh0000;
   localparam logic signed [15:0] LOW_RESET = 16'sh8000;
   localparam logic signed [15:0] HIGH_RESET = 16'sh7fff;
   localparam logic [7:0] ERR_PRESET = 8'h37;
   localparam logic [7:0] ERR_NONE = 8'h00;

   typedef struct packed {
      logic irq_en;
      logic reset_hold;
      logic up_down;
      logic rung;
   } ctrl_s;

   typedef enum logic [1:0] {
      ST_WAIT = 2'b01,
      ST_RUN = 2'b10
   } run_state_e;
endpackage

// file: rtl/input_edges.sv
// off-to-on edge detector for the counter input pins
// assumes inputs already synchronous to clock_i
`timescale 1ns/1ps
module input_edges #(
   parameter int W = 4
) (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic [W-1:0] level_i,
   output logic [W-1:0] rise_o
);
   logic [W-1:0] prev_reg;

   // preset high so a pin already on at reset makes no edge
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         prev_reg <= '1;
      end else if (ce_i) begin
         prev_reg <= level_i;
      end
   end

   assign rise_o = level_i & ~prev_reg & {W{ce_i}};
endmodule // input_edges

// file: verif/fast_counter_test.sv
// self-checking bench of the fast counter over apb
// assumes the field sensor model sits on count_in_i
`timescale 1ns/1ps
module fast_counter_test;
   typedef struct {
      logic [3:0] ctrl;
      logic [3:0] base;
      logic [3:0] hit;
      logic s;
      logic [15:0] delta;
   } row_s;
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic slow = 1'b0;
   int pulse_cnt = 0;
   int pulse_base = 0;
   logic ready, err, slverr, irq, irq_pulse;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic [3:0] want = 4'h0;
   logic [3:0] pins;
   logic [15:0] acc;
   int error_cnt = 0;
   int check_count = 0;
   int cycles = 0;
   row_s rows [9] = '{
      '{4'h1, 4'h0, 4'h1, 1'b0, 16'h0001}, '{4'h1, 4'h2, 4'h1, 1'b1, 16'hffff},
      '{4'h3, 4'h0, 4'h1, 1'b0, 16'h0001}, '{4'h3, 4'h1, 4'h2, 1'b1, 16'hffff},
      '{4'h3, 4'h0, 4'h3, 1'b0, 16'h0000}, '{4'h2, 4'h0, 4'h1, 1'b0, 16'h0000},
      '{4'h5, 4'h0, 4'h1, 1'b0, 16'h0001}, '{4'h5, 4'h8, 4'h1, 1'b0, 16'h0000},
      '{4'h7, 4'h8, 4'h2, 1'b1, 16'h0000}};
   logic [7:0] rst_adr [7] = '{8'h14, 8'h18, 8'h1c, 8'h0c, 8'h10, 8'h20, 8'h00};
   logic [31:0] rst_val [7] = '{32'h0, 32'h7fff, 32'h8000, 32'h7fff,
      32'h8000, 32'h0, 32'h0};

   fast_counter dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
      .pwdata_i(pwdata), .pready_o(ready), .prdata_o(prdata),
      .pslverr_o(slverr), .count_in_i(pins), .irq_o(irq),
      .irq_pulse_o(irq_pulse));
   field_sensors sensors (.clock_i(clock_i), .slow_i(slow), .want_i(want),
      .pins_o(pins));

   always #10 clock_i = ~clock_i;

   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (irq_pulse === 1'b1) begin
         pulse_cnt <= pulse_cnt + 1;
      end
      if (cycles == 20000) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] e, got);
      check_count++;
      if (got !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, e, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      pen <= 1'b1;
      do begin
         @(posedge clock_i);
      end while (ready !== 1'b1);
      rd = prdata;
      err = slverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clock_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd);
   endtask

   task automatic pulse(input logic [3:0] m);
      want <= want | m;
      repeat (4) @(posedge clock_i);
      want <= want & ~m;
      repeat (4) @(posedge clock_i);
   endtask

   initial begin
      repeat (20) @(posedge clock_i);
      reset_n_i <= 1'b1;
      @(negedge clock_i);
      chk("prdata after reset", 32'h0, prdata);
      chk("irq pulse after reset", 32'h0, irq_pulse);
      @(posedge clock_i);
      foreach (rst_adr[i])
         rc(rst_adr[i], rst_val[i]);
      chk("irq", 1'b0, irq);
      $display("reset test done");
      wr(8'h08, 32'h0010);
      wr(8'h0c, 32'h0020);
      wr(8'h00, 32'h1);
      rc(8'h14, 32'h0010);
      rc(8'h18, 32'h0020);
      wr(8'h08, 32'h0030);
      wr(8'h14, 32'h1234);
      rc(8'h14, 32'h0010);
      foreach (rows[i]) begin
         wr(8'h00, {28'h0, rows[i].ctrl});
         slow <= rows[i].s;
         want <= rows[i].base;
         repeat (4) @(posedge clock_i);
         apb(1'b0, 8'h14, 32'h0);
         acc = rd[15:0] + rows[i].delta;
         pulse(rows[i].hit);
         rc(8'h14, {16'h0, acc});
         $display("row %0d done", i);
      end
      wr(8'h00, 32'h9);
      wr(8'h24, 32'h1);
      wr(8'h08, 32'h001f);
      wr(8'h04, 32'h2);
      want <= 4'h0;
      pulse_base = pulse_cnt;
      pulse(4'h1);
      rc(8'h20, 32'h1);
      rc(8'h28, 32'h1);
      rc(8'h14, 32'h0020);
      rc(8'h18, 32'h0020);
      chk("irq", 1'b1, irq);
      chk("irq pulses", 32'h1, pulse_cnt - pulse_base);
      wr(8'h20, 32'h1f);
      rc(8'h20, 32'h0);
      chk("irq", 1'b0, irq);
      $display("high preset test done");
      wr(8'h24, 32'h0);
      wr(8'h08, 32'h8000);
      wr(8'h04, 32'h2);
      rc(8'h14, 32'h8000);
      rc(8'h20, 32'h2);
      rc(8'h28, 32'h2);
      chk("irq", 1'b0, irq);
      wr(8'h20, 32'h1f);
      wr(8'h00, 32'hb);
      pulse(4'h2);
      rc(8'h14, 32'h7fff);
      rc(8'h20, 32'h8);
      rc(8'h28, 32'h8);
      wr(8'h20, 32'h1f);
      pulse(4'h1);
      rc(8'h14, 32'h8000);
      rc(8'h20, 32'h4);
      rc(8'h28, 32'h4);
      wr(8'h20, 32'h1f);
      $display("wrap test done");
      wr(8'h10, 32'h0030);
      wr(8'h0c, 32'h0020);
      wr(8'h04, 32'h4);
      apb(1'b0, 8'h20, 32'h0);
      chk("preset error", 1'b1, rd[4]);
      rc(8'h2c, 32'h37);
      wr(8'h20, 32'h1f);
      rc(8'h2c, 32'h0);
      wr(8'h10, 32'hfff0);
      wr(8'h0c, 32'h0050);
      wr(8'h04, 32'h4);
      rc(8'h18, 32'h0050);
      rc(8'h1c, 32'hfff0);
      rc(8'h20, 32'h2);
      wr(8'h20, 32'h1f);
      $display("preset load test done");
      wr(8'h00, 32'h5);
      pulse(4'h4);
      rc(8'h14, 32'h0);
      wr(8'h08, 32'h0005);
      wr(8'h04, 32'h2);
      rc(8'h14, 32'h0005);
      wr(8'h04, 32'h1);
      rc(8'h14, 32'h0);
      chk("mapped err", 32'h0, err);
      apb(1'b0, 8'hfc, 32'h0);
      chk("unmapped err", 1'b1, err);
      chk("unmapped data", 32'h0, rd);
      $display("command test done");
      wr(8'h08, 32'hfff1);
      wr(8'h04, 32'h2);
      wr(8'h00, 32'h3);
      pulse(4'h2);
      rc(8'h14, 32'hfff0);
      rc(8'h20, 32'h2);
      rc(8'h28, 32'h2);
      $display("low step test done");
      reset_n_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      reset_n_i <= 1'b1;
      @(negedge clock_i);
      chk("irq after reset", 32'h0, irq);
      chk("pulse after reset", 32'h0, irq_pulse);
      @(posedge clock_i);
      rc(8'h1c, 32'h8000);
      rc(8'h18, 32'h7fff);
      rc(8'h20, 32'h0);
      rc(8'h00, 32'h0);
      $display("mid-run reset test done");
      summarize();
   end
endmodule // fast_counter_test

// file: verif/field_sensors.sv
// field sensor model driving the four count pins of the fast counter
// assumes the pins are sampled on the rising edge of clock_i
`timescale 1ns/1ps
module field_sensors (
   input wire logic clock_i,
   input wire logic slow_i,
   input wire logic [3:0] want_i,
   output logic [3:0] pins_o
);
   logic lag_reg = 1'b0;
   logic [3:0] pins_reg = 4'h0;
   logic skip;
   // a slow sensor settles only on every second edge
   assign skip = slow_i & ~lag_reg;
   assign pins_o = pins_reg;
   always @(posedge clock_i) begin
      lag_reg <= skip;
      if (!skip) begin
         pins_reg <= want_i;
      end
   end
endmodule // field_sensors
